// ==== rtl/pms_sequencer.sv ====
// Power mode sequencer: mode register, power-down entry, key wake, reset timing.
// Assumes a host byte port synchronous to clk_i and an active-low power-on reset pin.
// Assumes key_n_i may move while the oscillator is stopped.
// Assumes osc_valid_i is a level produced in the clk_i domain.
// Assumes ce_i low holds every flop but the key latch, the synchronisers included.
`timescale 1ns/1ps
module pms_sequencer #(
  parameter int WAKE_HOLD_CYC = pms_pkg::PMS_WAKE_HOLD_CYC,
  parameter int WARMUP_CYC = pms_pkg::PMS_WARMUP_CYC
) (
  // Clock, enable and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic por_n_i,
  // Host register port
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic cmd_o,
  output logic [7:0] cmd_addr_o,
  // Key inputs and oscillator status
  input wire logic [7:0] key_n_i,
  input wire logic osc_valid_i,
  // System outputs
  output logic supply_enable_out_o,
  output logic system_reset_out_o,
  output logic host_interrupt_out_o,
  output logic osc_enable_o,
  output logic host_if_enable_o,
  // Circuit power enables
  output logic core_power_o,
  output logic wb_rx_power_o,
  output logic dtmf_power_o,
  output logic rx_audio_power_o,
  output logic full_path_power_o,
  output logic [3:0] aux_power_o
);

  // ****************************************
  // State record
  // ****************************************
  // Every flop of the block but the key latch and the two synchronisers lives in this record, so one clock-enable test
  // freezes all of it. Power outputs are decoded from the next state into the
  // record, which keeps each top-level output straight off a flop.
  // The price is one level of logic in front of the register.
  typedef struct packed {
    pms_pkg::pms_state_t state;
    logic [4:0] mode;
    logic [7:0] irq_en;
    logic [7:0] key_dir;
    logic [7:0] key_pull;
    logic [7:0] key_irq_en;
    logic [7:0] rf_timer;
    logic [3:0] aux;
    logic key_event;
    logic woke;
    logic hold;
    logic [pms_pkg::PMS_CNT_W-1:0] cnt;
    logic [7:0] rdata;
    logic cmd;
    logic [7:0] cmd_addr;
    logic supply;
    logic sys_rst;
    logic irq;
    logic osc_en;
    logic if_en;
    logic core;
    logic wb_rx;
    logic dtmf;
    logic rx_audio;
    logic full;
    logic [3:0] aux_out;
    logic wake_ack;
  } pms_regs_t;

  // Present and next copies of the record, then the glue around them.
  // The glue is all combinational; nothing here holds state of its own.
  pms_regs_t st_reg;
  pms_regs_t st_next;
  logic por_ok;
  logic wake_async;
  logic wake_sync;
  logic [7:0] key_arm_vec;
  logic key_armed;
  logic cmd_addr_hit;
  logic pd_write;

  // A key is armed only when its pin interrupt is enabled, its pin is an input
  // and the port interrupt is enabled. Anything less leaves the block unable
  // to wake, and only rst_i can then bring it back.
  // Pull-up control is stored but does not gate the wake.
  assign key_arm_vec = st_reg.key_irq_en & ~st_reg.key_dir;
  assign key_armed = (|key_arm_vec) & st_reg.irq_en[pms_pkg::PMS_IE_KEY_BIT];

  // ****************************************
  // Wake path
  // ****************************************
  // The latch is clockless on the set side, since in power-down the clock is off.
  // Hazard: the set is a combinational level, so a glitch on an armed key line
  // in power-down reads as a press. The state term in the arm keeps keys inert
  // while the block runs. The acknowledge is gated by ce_i so that a frozen
  // block never loses a wake it has not yet taken.
  pms_key_latch u_key_latch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ack_i(st_reg.wake_ack && ce_i),
    .arm_i(key_armed && (st_reg.state == pms_pkg::PMS_ST_POWERDOWN)),
    .key_n_i(&(key_n_i | ~key_arm_vec)),
    .wake_o(wake_async)
  );

  // Both slow levels enter the clock domain through two flops. The wake pays
  // two cycles for it, which is nothing against the reset hold.
  pms_sync2 u_wake_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(ce_i),
    .d_i(wake_async),
    .q_o(wake_sync)
  );

  // The power-on reset pin is a plain level. Only the settled copy is read,
  // so a slow edge on it cannot split the outputs across two cycles.
  pms_sync2 u_por_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(ce_i),
    .d_i(por_n_i),
    .q_o(por_ok)
  );

  // Command addresses, barred while in shutdown. The reset command is matched
  // here as well and let through below, since it stays legal in shutdown.
  // Register addresses never reach this test; the write case takes them first.
  assign cmd_addr_hit = ((addr_i >= pms_pkg::PMS_CMD_FIRST) && (addr_i <= pms_pkg::PMS_CMD_LAST))
                        || (addr_i == pms_pkg::PMS_CMD_EXTRA) || (addr_i == pms_pkg::PMS_CMD_RESET);

  // Power-down needs the code and both low bits changed by the same write.
  // Bit 1 is the safety bit: a write of the code that leaves either low bit
  // unchanged only selects shutdown. From mode 01H the code flips both bits,
  // from 00H it does not, so the host steps through 01H first.
  assign pd_write = wr_i && st_reg.if_en && (addr_i == pms_pkg::PMS_ADDR_POWER_MODE)
                    && (wdata_i[pms_pkg::PMS_MODE_MSB:0] == pms_pkg::PMS_CODE_POWERDOWN)
                    && (wdata_i[pms_pkg::PMS_SAFETY_BIT] != st_reg.mode[pms_pkg::PMS_SAFETY_BIT])
                    && (wdata_i[0] != st_reg.mode[0]);

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.cmd = 1'b0;
    st_next.wake_ack = 1'b0;
    st_next.rdata = pms_pkg::PMS_BYTE_RESET;
    // Register writes through the host port; unmapped addresses are ignored.
    // Writes are refused while the interface is off, which covers power-down
    // and the whole of the wake reset hold.
    if (wr_i && st_reg.if_en) begin
      case (addr_i)
        pms_pkg::PMS_ADDR_POWER_MODE: begin
          st_next.mode = wdata_i[pms_pkg::PMS_MODE_MSB:0];
        end
        pms_pkg::PMS_ADDR_IRQ_ENABLE_TWO: begin
          st_next.irq_en = wdata_i;
        end
        pms_pkg::PMS_ADDR_KEY_DIRECTION: begin
          st_next.key_dir = wdata_i;
        end
        pms_pkg::PMS_ADDR_KEY_PULLUP: begin
          st_next.key_pull = wdata_i;
        end
        pms_pkg::PMS_ADDR_KEY_PIN_IRQ_EN: begin
          st_next.key_irq_en = wdata_i;
        end
        pms_pkg::PMS_ADDR_RF_IDLE_TIMER: begin
          st_next.rf_timer = wdata_i;
        end
        pms_pkg::PMS_ADDR_AUX_POWER: begin
          st_next.aux = wdata_i[3:0];
        end
        default: begin
          // Command strobes pass on except the barred set in shutdown.
          if (cmd_addr_hit) begin
            if ((st_reg.state != pms_pkg::PMS_ST_SHUTDOWN) ||
                (addr_i == pms_pkg::PMS_CMD_RESET)) begin
              st_next.cmd = 1'b1;
              st_next.cmd_addr = addr_i;
            end
          end
        end
      endcase
    end

    // Event register read clears the keypad flag, but a new wake wins.
    // The wake and interrupt branches assign later in this process, so a wake
    // and a read in one cycle leave the flag set, and a read as the interrupt rises leaves it set.
    if (rd_i && st_reg.if_en && (addr_i == pms_pkg::PMS_ADDR_EVENT_STATUS_TWO)) begin
      st_next.rdata = {7'h00, st_reg.key_event};
      st_next.key_event = 1'b0;
      st_next.irq = 1'b0;
    end

    // Mode selection follows the mode word.
    // Power-down is left only through the key wake or rst_i; a code that is
    // not a mode of its own falls back to shutdown.
    // The code is taken from the next copy so a new mode acts at once.
    case (st_reg.state)
      pms_pkg::PMS_ST_POWERDOWN: begin
        if (wake_sync) begin
          st_next.state = pms_pkg::PMS_ST_SHUTDOWN;
          st_next.mode = pms_pkg::PMS_MODE_RESET;
          st_next.key_event = 1'b1;
          st_next.woke = 1'b1;
          st_next.hold = 1'b1;
          st_next.cnt = '0;
          st_next.wake_ack = 1'b1;
        end
      end
      default: begin
        if (pd_write) begin
          st_next.state = pms_pkg::PMS_ST_POWERDOWN;
        end else begin
          case (st_next.mode)
            pms_pkg::PMS_CODE_IDLE: st_next.state = pms_pkg::PMS_ST_IDLE;
            pms_pkg::PMS_CODE_TONE: st_next.state = pms_pkg::PMS_ST_TONE;
            pms_pkg::PMS_CODE_FULL_OFF: st_next.state = pms_pkg::PMS_ST_FULL_OFF;
            pms_pkg::PMS_CODE_FULL_ON: st_next.state = pms_pkg::PMS_ST_FULL_ON;
            default: st_next.state = pms_pkg::PMS_ST_SHUTDOWN;
          endcase
        end
      end
    endcase

    // Wake reset hold counts only once the oscillator reports valid.
    // If the oscillator drops out during the hold the count pauses rather than
    // restarting, so the hold can only grow, never shrink.
    // The counter width bounds the longest hold that can be set.
    // Time spent with ce_i low simply stretches the hold.
    if (st_reg.hold && osc_valid_i) begin
      if (st_reg.cnt == pms_pkg::PMS_CNT_W'(WAKE_HOLD_CYC + WARMUP_CYC - 1)) begin
        st_next.hold = 1'b0;
      end else begin
        st_next.cnt = st_reg.cnt + 1'b1;
      end
    end

    // Interrupt appears after a wake-boot only.
    // It rises on the edge that releases the system reset, so the host sees
    // the cause as soon as it runs; a battery-connect boot never sets it.
    if (st_reg.woke && !st_next.hold && por_ok) begin
      st_next.irq = 1'b1;
      st_next.woke = 1'b0;
    end

    // Output decode per power state.
    // Supply, oscillator and core follow the supply term, so power-down drops
    // them together. The auxiliary enables pass only while the supply is on,
    // which overrides whatever the host stored in them.
    st_next.supply = (st_next.state != pms_pkg::PMS_ST_POWERDOWN);
    st_next.sys_rst = st_next.supply && por_ok && !st_next.hold;
    st_next.if_en = st_next.sys_rst;
    st_next.osc_en = st_next.supply;
    st_next.core = st_next.supply;
    st_next.wb_rx = (st_next.state == pms_pkg::PMS_ST_IDLE) ||
                    (st_next.state == pms_pkg::PMS_ST_FULL_OFF) ||
                    (st_next.state == pms_pkg::PMS_ST_FULL_ON);
    st_next.dtmf = (st_next.state == pms_pkg::PMS_ST_TONE) ||
                   (st_next.state == pms_pkg::PMS_ST_FULL_ON);
    st_next.rx_audio = (st_next.state == pms_pkg::PMS_ST_TONE) ||
                       (st_next.state == pms_pkg::PMS_ST_FULL_OFF) ||
                       (st_next.state == pms_pkg::PMS_ST_FULL_ON);
    st_next.full = (st_next.state == pms_pkg::PMS_ST_FULL_OFF) ||
                   (st_next.state == pms_pkg::PMS_ST_FULL_ON);
    st_next.aux_out = st_next.supply ? st_next.aux : pms_pkg::PMS_AUX_RESET;
  end

  // ****************************************
  // State register
  // ****************************************
  // Clock enable freezes all state but the key latch; reset is battery connect into shutdown.
  // The reset branch gives constants only; the supply is raised at once so the
  // host powers up while the power-on reset pin is still low.
  // A mid-run rst_i is the only way out of an unarmed power-down.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.state <= pms_pkg::PMS_ST_SHUTDOWN;
      st_reg.supply <= 1'b1;
      st_reg.osc_en <= 1'b1;
      st_reg.core <= 1'b1;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  // Outputs come straight from the state record.
  // No output is decoded after the register, so none can glitch.
  assign rdata_o = st_reg.rdata;
  assign cmd_o = st_reg.cmd;
  assign cmd_addr_o = st_reg.cmd_addr;
  assign supply_enable_out_o = st_reg.supply;
  assign system_reset_out_o = st_reg.sys_rst;
  assign host_interrupt_out_o = st_reg.irq;
  assign osc_enable_o = st_reg.osc_en;
  assign host_if_enable_o = st_reg.if_en;
  assign core_power_o = st_reg.core;
  assign wb_rx_power_o = st_reg.wb_rx;
  assign dtmf_power_o = st_reg.dtmf;
  assign rx_audio_power_o = st_reg.rx_audio;
  assign full_path_power_o = st_reg.full;
  assign aux_power_o = st_reg.aux_out;

endmodule // pms_sequencer

// ==== rtl/pms_pkg.sv ====
// Constants, register map and mode encodings for the power mode sequencer.
// Assumes a 100 MHz core clock and an 8-bit host register port.
package pms_pkg;

  // ****************************************
  // Register write and read addresses
  // ****************************************
  localparam logic [7:0] PMS_ADDR_POWER_MODE = 8'h03;
  localparam logic [7:0] PMS_ADDR_IRQ_ENABLE_TWO = 8'h06;
  localparam logic [7:0] PMS_ADDR_EVENT_STATUS_TWO = 8'h06;
  localparam logic [7:0] PMS_ADDR_KEY_DIRECTION = 8'h19;
  localparam logic [7:0] PMS_ADDR_KEY_PULLUP = 8'h1b;
  localparam logic [7:0] PMS_ADDR_KEY_PIN_IRQ_EN = 8'h1c;
  localparam logic [7:0] PMS_ADDR_RF_IDLE_TIMER = 8'h20;
  localparam logic [7:0] PMS_ADDR_AUX_POWER = 8'h30;
  localparam logic [7:0] PMS_CMD_FIRST = 8'h08;
  localparam logic [7:0] PMS_CMD_LAST = 8'h0c;
  localparam logic [7:0] PMS_CMD_EXTRA = 8'h0e;
  localparam logic [7:0] PMS_CMD_RESET = 8'h0d;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int PMS_MODE_MSB = 4;
  localparam int PMS_SAFETY_BIT = 1;
  localparam int PMS_EVT_KEY_BIT = 0;
  localparam int PMS_IE_KEY_BIT = 0;
  localparam logic [4:0] PMS_CODE_POWERDOWN = 5'h02;
  localparam logic [4:0] PMS_CODE_SHUTDOWN = 5'h00;
  localparam logic [4:0] PMS_CODE_IDLE = 5'h01;
  localparam logic [4:0] PMS_CODE_TONE = 5'h04;
  localparam logic [4:0] PMS_CODE_FULL_OFF = 5'h05;
  localparam logic [4:0] PMS_CODE_FULL_ON = 5'h06;
  localparam logic [4:0] PMS_MODE_RESET = 5'h00;
  localparam logic [7:0] PMS_BYTE_RESET = 8'h00;
  localparam logic [3:0] PMS_AUX_RESET = 4'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int PMS_CLK_MHZ = 100;
  localparam int PMS_WAKE_HOLD_MS = 150;
  localparam int PMS_WARMUP_US = 1000;
  localparam int PMS_WAKE_HOLD_CYC = PMS_WAKE_HOLD_MS * 1000 * PMS_CLK_MHZ;
  localparam int PMS_WARMUP_CYC = PMS_WARMUP_US * PMS_CLK_MHZ;
  localparam int PMS_CNT_W = 25;

  // ****************************************
  // Power states, one-hot
  // ****************************************
  typedef enum logic [5:0] {
    PMS_ST_SHUTDOWN = 6'b000001,
    PMS_ST_IDLE = 6'b000010,
    PMS_ST_TONE = 6'b000100,
    PMS_ST_FULL_OFF = 6'b001000,
    PMS_ST_FULL_ON = 6'b010000,
    PMS_ST_POWERDOWN = 6'b100000
  } pms_state_t;

endpackage : pms_pkg

// ==== rtl/pms_key_latch.sv ====
// Clockless key wake latch: set by an enabled key level, cleared by a clocked ack.
// Assumes the key line is low while pressed and the arm level is held steady.
`timescale 1ns/1ps
module pms_key_latch (
  // Clear side
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ack_i,
  // Key side
  input wire logic arm_i,
  input wire logic key_n_i,
  // Result
  output logic wake_o
);

  logic press;

  // The press acts as an asynchronous set so no clock is needed to catch it.
  assign press = arm_i & ~key_n_i;

  // Set wins over the acknowledge because the asynchronous set is tested first.
  always_ff @(posedge clk_i or posedge rst_i or posedge press) begin
    if (rst_i) begin
      wake_o <= 1'b0;
    end else if (press) begin
      wake_o <= 1'b1;
    end else if (ack_i) begin
      wake_o <= 1'b0;
    end
  end

endmodule // pms_key_latch

// ==== rtl/pms_sync2.sv ====
// Two-flop synchroniser for a single level; it holds while en_i is low.
// Assumes the input may change at any time relative to clk_i.
`timescale 1ns/1ps
module pms_sync2 (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  // Level
  input wire logic d_i,
  output logic q_o
);

  logic meta_reg;

  // First stage feeds only the second stage.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      q_o <= 1'b0;
    end else if (en_i) begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule // pms_sync2

// ==== testbench/pms_sequencer_properties.sv ====
// Port-level assertions for the power mode sequencer, bound into each instance.
// Assumes one clock domain and the asynchronous active-high reset rst_i.
`timescale 1ns/1ps
module pms_sequencer_properties #(
  parameter int WAKE_HOLD_CYC = 20,
  parameter int WARMUP_CYC = 5
) (
  // Clock, reset and host side
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_n_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic osc_valid_i,
  // Observed outputs
  input wire logic cmd_o,
  input wire logic [7:0] cmd_addr_o,
  input wire logic supply_enable_out_o,
  input wire logic system_reset_out_o,
  input wire logic host_interrupt_out_o,
  input wire logic osc_enable_o,
  input wire logic host_if_enable_o,
  input wire logic core_power_o,
  input wire logic wb_rx_power_o,
  input wire logic dtmf_power_o,
  input wire logic rx_audio_power_o,
  input wire logic full_path_power_o,
  input wire logic [3:0] aux_power_o
);
  localparam int HOLD = WAKE_HOLD_CYC + WARMUP_CYC;
  logic [3:0] pd_hist;
  logic wake_q;
  logic [31:0] low_cnt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ****************************************
  // Helper logic
  // ****************************************
  // History of power-down writes, and the reset-hold length seen after a wake.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pd_hist <= 4'h0;
      wake_q <= 1'b0;
      low_cnt <= '0;
    end else begin
      pd_hist <= {pd_hist[2:0], wr_i && addr_i == 8'h03 && wdata_i[4:0] == 5'h02};
      if (!supply_enable_out_o) begin
        wake_q <= 1'b1;
        low_cnt <= '0;
      end else if (system_reset_out_o) begin
        wake_q <= 1'b0;
      end else if (osc_valid_i) begin
        low_cnt <= low_cnt + 1;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  pd_cause_a: assert property ($fell(supply_enable_out_o) |-> |pd_hist)
    else $error("supply dropped without a power-down write");
  pd_outputs_a: assert property (!supply_enable_out_o |->
    !system_reset_out_o && !host_if_enable_o && !osc_enable_o)
    else $error("power-down outputs wrong");
  pd_override_a: assert property (!osc_enable_o |->
    aux_power_o == 4'h0 && !core_power_o && !wb_rx_power_o)
    else $error("circuits powered while stopped");
  wake_hold_a: assert property ($rose(system_reset_out_o) && wake_q |->
    low_cnt >= HOLD && low_cnt <= HOLD + 3)
    else $error("wake reset hold length wrong");
  intr_boot_a: assert property ($rose(host_interrupt_out_o) |->
    $rose(system_reset_out_o))
    else $error("interrupt rose apart from reset release");
  por_hold_a: assert property (!por_n_i |-> ##3 !system_reset_out_o)
    else $error("system reset high while power-on reset low");
  rst_rise_a: assert property ($rose(system_reset_out_o) |->
    host_if_enable_o && supply_enable_out_o)
    else $error("reset released with interface off");
  cmd_block_a: assert property (cmd_o && !wb_rx_power_o && !dtmf_power_o |->
    cmd_addr_o == 8'h0d || cmd_addr_o < 8'h08 || cmd_addr_o > 8'h0e)
    else $error("command passed in shutdown");
  cmd_pass_a: assert property (wr_i && host_if_enable_o && addr_i == 8'h0d |->
    ##[1:2] cmd_o)
    else $error("reset command not passed");
  full_set_a: assert property (full_path_power_o |->
    wb_rx_power_o && rx_audio_power_o && core_power_o)
    else $error("full mode missing a circuit");
  tone_set_a: assert property (dtmf_power_o |-> rx_audio_power_o && core_power_o)
    else $error("tone generator without audio");

  cover property ($fell(supply_enable_out_o));
  cover property ($rose(host_interrupt_out_o));
  cover property (cmd_o && !wb_rx_power_o);
endmodule // pms_sequencer_properties

bind pms_sequencer pms_sequencer_properties #(
  .WAKE_HOLD_CYC(WAKE_HOLD_CYC),
  .WARMUP_CYC(WARMUP_CYC)
) i_pms_sequencer_properties (.clk_i, .rst_i, .por_n_i, .wr_i, .addr_i, .wdata_i,
  .osc_valid_i, .cmd_o, .cmd_addr_o, .supply_enable_out_o, .system_reset_out_o,
  .host_interrupt_out_o, .osc_enable_o, .host_if_enable_o, .core_power_o,
  .wb_rx_power_o, .dtmf_power_o, .rx_audio_power_o, .full_path_power_o, .aux_power_o);

// ==== testbench/pms_osc_model.sv ====
// Crystal oscillator model: reports valid only after a warm-up count.
// Assumes the sequencer's oscillator enable; the sim clock itself never stops.
`timescale 1ns/1ps
module pms_osc_model #(
  parameter int WARM = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Oscillator control and status
  input wire logic osc_enable_i,
  output logic osc_valid_o
);
  int cnt;

  // A stopped oscillator loses its warm-up at once, so a wake always pays it again.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
    end else if (!osc_enable_i) begin
      cnt <= 0;
    end else if (cnt < WARM) begin
      cnt <= cnt + 1;
    end
  end
  assign osc_valid_o = osc_enable_i && (cnt >= WARM);
endmodule // pms_osc_model

// ==== testbench/pms_sequencer_bench.sv ====
// Self-checking bench for the power mode sequencer with an oscillator model.
// Assumes short wake counts (20 and 5) so a wake takes a few dozen cycles.
`timescale 1ns/1ps
module pms_sequencer_bench;
  logic clk_i, rst_i, ce_i, por_n_i, wr_i, rd_i, osc_valid_i, cmd_o, osc_enable_o;
  logic [7:0] addr_i, wdata_i, key_n_i, rdata_o, cmd_addr_o, d;
  logic supply_enable_out_o, system_reset_out_o, host_interrupt_out_o, host_if_enable_o;
  logic core_power_o, wb_rx_power_o, dtmf_power_o, rx_audio_power_o, full_path_power_o;
  logic [3:0] aux_power_o;
  logic s;
  int n_mismatch, compares, n;
  logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
  logic [3:0] pwr [5] = '{4'b0000, 4'b1000, 4'b0110, 4'b1011, 4'b1111};

  pms_sequencer #(.WAKE_HOLD_CYC(20), .WARMUP_CYC(5)) i_pms_sequencer (.clk_i, .rst_i,
    .ce_i, .por_n_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o, .cmd_o, .cmd_addr_o,
    .key_n_i, .osc_valid_i, .supply_enable_out_o, .system_reset_out_o,
    .host_interrupt_out_o, .osc_enable_o, .host_if_enable_o, .core_power_o,
    .wb_rx_power_o, .dtmf_power_o, .rx_audio_power_o, .full_path_power_o, .aux_power_o);
  pms_osc_model #(.WARM(3)) i_pms_osc_model (.clk_i, .rst_i,
    .osc_enable_i(osc_enable_o), .osc_valid_o(osc_valid_i));

  // Free-running 100 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One write strobe per call; the strobe is low for a cycle between calls.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_i);
    wr_i = 1'b1; addr_i = a; wdata_i = v;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask
  // Read data stands one cycle, so both candidate cycles are merged.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk_i);
    rd_i = 1'b1; addr_i = a;
    @(negedge clk_i);
    rd_i = 1'b0; v = rdata_o;
    @(negedge clk_i);
    v = v | rdata_o;
  endtask
  task automatic cmd_seen(output logic v);
    v = 1'b0;
    repeat (3) begin v = v | cmd_o; @(negedge clk_i); end
  endtask
  task automatic enter_pd();
    wr_reg(8'h03, 8'h01);
    wr_reg(8'h03, 8'h02);
    repeat (4) @(negedge clk_i);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_battery();
    repeat (6) @(negedge clk_i);
    chk("supply", 8'h01, {7'h0, supply_enable_out_o});
    chk("sysrst", 8'h00, {7'h0, system_reset_out_o});
    por_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("sysrst", 8'h01, {7'h0, system_reset_out_o});
    chk("if_en", 8'h01, {7'h0, host_if_enable_o});
    chk("intr", 8'h00, {7'h0, host_interrupt_out_o});
    $display("test battery done");
  endtask
  task automatic t_modes();
    wr_reg(8'h30, 8'h0f);
    for (int i = 0; i < 5; i++) begin
      wr_reg(8'h03, codes[i]);
      repeat (3) @(negedge clk_i);
      chk("power", {4'h0, pwr[i]}, {4'h0, wb_rx_power_o, dtmf_power_o, rx_audio_power_o,
        full_path_power_o});
      chk("aux", 8'h0f, {4'h0, aux_power_o});
    end
    ce_i = 1'b0;
    wr_reg(8'h03, 8'h00);
    repeat (2) @(negedge clk_i);
    ce_i = 1'b1;
    chk("frozen", 8'h0f, {4'h0, wb_rx_power_o, dtmf_power_o, rx_audio_power_o,
      full_path_power_o});
    wr_reg(8'h03, 8'h02);
    repeat (4) @(negedge clk_i);
    chk("supply", 8'h01, {7'h0, supply_enable_out_o});
    $display("test modes done");
  endtask
  task automatic t_cmds();
    wr_reg(8'h03, 8'h00);
    chk("shut_on", 8'h07, {5'h0, core_power_o, host_if_enable_o, osc_enable_o});
    for (logic [7:0] a = 8'h08; a <= 8'h0e; a++) begin
      wr_reg(a, 8'h00);
      cmd_seen(s);
      chk("cmd", {7'h0, a == 8'h0d}, {7'h0, s});
    end
    wr_reg(8'h03, 8'h01);
    wr_reg(8'h08, 8'h00);
    cmd_seen(s);
    chk("cmd", 8'h01, {7'h0, s});
    chk("cmd_addr", 8'h08, cmd_addr_o);
    $display("test commands done");
  endtask
  task automatic t_wake();
    wr_reg(8'h1c, 8'h01);
    wr_reg(8'h1b, 8'h01);
    wr_reg(8'h19, 8'h00);
    wr_reg(8'h06, 8'h01);
    enter_pd();
    chk("pd_out", 8'h00, {3'h0, core_power_o, supply_enable_out_o, system_reset_out_o,
      host_if_enable_o, osc_enable_o});
    chk("aux", 8'h00, {4'h0, aux_power_o});
    key_n_i = 8'hfe;
    n = 0;
    while (supply_enable_out_o !== 1'b1 && n < 50) begin @(negedge clk_i); n++; end
    chk("supply", 8'h01, {7'h0, supply_enable_out_o});
    n = 0;
    while (system_reset_out_o !== 1'b1 && n < 200) begin @(negedge clk_i); n++; end
    key_n_i = 8'hff;
    chk("hold", 8'h01, {7'h0, n >= 25 && n <= 40});
    chk("intr", 8'h01, {7'h0, host_interrupt_out_o});
    rd_reg(8'h06, d);
    chk("event", 8'h01, d & 8'h01);
    chk("intr", 8'h00, {7'h0, host_interrupt_out_o});
    $display("test wake done");
  endtask
  task automatic t_unarmed();
    wr_reg(8'h1c, 8'h00);
    enter_pd();
    key_n_i = 8'hfe;
    repeat (40) @(negedge clk_i);
    chk("supply", 8'h00, {7'h0, supply_enable_out_o});
    key_n_i = 8'hff;
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (5) @(negedge clk_i);
    chk("sysrst", 8'h01, {7'h0, system_reset_out_o});
    $display("test unarmed done");
  endtask

  // Main sequence.
  initial begin
    n_mismatch = 0; compares = 0;
    rst_i = 1'b1; ce_i = 1'b1; por_n_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0;
    addr_i = 8'h00; wdata_i = 8'h00; key_n_i = 8'hff;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    t_battery();
    t_modes();
    t_cmds();
    t_wake();
    t_unarmed();
    give_verdict();
  end
endmodule // pms_sequencer_bench
